// *** src/dss_pkg.sv ***
// Package of constants and types for the dual-slope converter sequencer
package dss_pkg;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int SAMPLE_MS = 25;
   localparam int AUTOZERO_MS = 40;
   localparam int EXTREME_MS = 100;
   localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
   localparam int AUTOZERO_CYC = CLK_HZ / 1000 * AUTOZERO_MS;
   localparam int EXTREME_CYC = CLK_HZ / 1000 * EXTREME_MS;
   localparam int SAMPLES_PER_GROUP = 8;
   localparam int FULL_SCALE = 4000;
   localparam int CNT_W = 16;
   localparam int TMR_W = 24;
   // ------------------------------------------------------------------
   // Timing modes written by the microcomputer
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      DSS_TM_BASIC = 3'h0,
      DSS_TM_HIGH_OHM = 3'h1,
      DSS_TM_OVERLOAD = 3'h2,
      DSS_TM_AUTORANGE = 3'h3,
      DSS_TM_HOLD = 3'h4,
      DSS_TM_EXTREME = 3'h5,
      DSS_TM_KNOB = 3'h6,
      DSS_TM_COUNTER = 3'h7
   } dss_tmode_t;
   // Sequencer states, Gray coded along the integrate/read/autozero path
   typedef enum logic [1:0] {
      DSS_ST_IDLE = 2'h0,
      DSS_ST_INTEG = 2'h1,
      DSS_ST_READ = 2'h3,
      DSS_ST_AZERO = 2'h2
   } dss_state_t;
   // Range codes, divider selects and current function codes
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_40V = 2'h1;
   localparam logic [1:0] RANGE_300V = 2'h2;
   localparam logic [1:0] DIV_10 = 2'h1;
   localparam logic [1:0] DIV_100 = 2'h2;
   localparam logic [1:0] DIV_1000 = 2'h3;
   localparam logic [2:0] FUNC_MA = 3'h4;
   localparam logic [2:0] FUNC_AMP = 3'h5;
endpackage

// *** src/dss_sequencer.sv ***
// Dual-slope converter sequencer, shared counter and input alert
// What this block does
// [R01] Each minor-cycle sample lasts 25 ms in basic timing; 50 ms in high-ohm, 100 ms in extremes mode.
// [R02] Every sample yields a fast result pulse.
// [R03] Eight samples make one full reading; one in autorange, overload, hold, knob and extremes modes.
// [R04] 40 ms autozero follows each eight-sample group.
// [R05] Carry residual from each sample onward.
// [R06] Special modes alter the basic group timing.
// [R07] Synchronous machine with one 16-bit counter.
// [R08] Counter mode counts comparator pulses.
// [R09] Microcomputer sets comparator offset.
// [R10] Low jack sense means lead inserted.
// [R11] Current jack lead, no current function: beep.
// [R12] Range selects divider 10, 100 or 1000.
// [R13] Microcomputer writes the switch-drive word.
// [R14] Microcomputer arms and clears the counter.
// [R15] Microcomputer bus inputs are synchronised.
// [R16] After autozero the next group restarts.
`timescale 1ns/1ps
module dss_sequencer #(
   parameter int SAMPLE_CYCLES = dss_pkg::SAMPLE_CYC,
   parameter int AUTOZERO_CYCLES = dss_pkg::AUTOZERO_CYC,
   parameter int EXTREME_CYCLES = dss_pkg::EXTREME_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] tmode_async,
   input wire logic [2:0] func_async,
   input wire logic [1:0] range_async,
   input wire logic [7:0] switch_word_async,
   input wire logic [3:0] cmp_offset_async,
   input wire logic count_arm_async,
   input wire logic count_clear_async,
   input wire logic comparator_in,
   input wire logic milliamp_jack_sense,
   input wire logic amp_jack_sense,
   output logic integrate_on,
   output logic deintegrate_on,
   output logic autozero_on,
   output logic sample_done,
   output logic reading_done,
   output logic [15:0] count_out,
   output logic [15:0] residual_out,
   output logic [1:0] divider_sel,
   output logic [7:0] switch_drive,
   output logic [3:0] cmp_offset,
   output logic beep_warn
);
   localparam int IN_W = 3 + 3 + 2 + 8 + 4 + 2 + 3;
   localparam int WORD_W = 3 + 3 + 2 + 8 + 4;
   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [IN_W-1:0] sy1_q, sy2_q;
   logic [IN_W-1:0] raw_in;
   logic [WORD_W-1:0] sy3_q, word_q, word_d;
   assign raw_in = {tmode_async, func_async, range_async, switch_word_async,
                    cmp_offset_async, count_arm_async, count_clear_async,
                    comparator_in, milliamp_jack_sense, amp_jack_sense};
   // Multi-bit words are taken only when two synced samples agree, so bit skew never leaks
   assign word_d = (sy2_q[IN_W-1:IN_W-WORD_W] == sy3_q) ? sy3_q : word_q; // [R15]
   // Two flops on every foreign input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= '1;
         sy2_q <= '1;
         sy3_q <= '1;
         word_q <= '1;
      end else begin
         sy1_q <= raw_in; // [R15]
         sy2_q <= sy1_q;
         sy3_q <= sy2_q[IN_W-1:IN_W-WORD_W];
         word_q <= word_d;
      end
   end
   dss_pkg::dss_tmode_t tmode;
   logic [2:0] tmode_bits;
   logic [2:0] func;
   logic [1:0] range;
   logic [7:0] sw_word;
   logic [3:0] offs;
   logic arm, clr, cmp, ma_n, a_n;
   assign {tmode_bits, func, range, sw_word, offs} = word_q;
   assign {arm, clr, cmp, ma_n, a_n} = sy2_q[IN_W-WORD_W-1:0];
   assign tmode = dss_pkg::dss_tmode_t'(tmode_bits);

   // Sample length per mode, longer for high ohms and extremes mode
   function automatic logic [dss_pkg::TMR_W-1:0] samp_len(input dss_pkg::dss_tmode_t m);
      if (m == dss_pkg::DSS_TM_EXTREME) begin
         samp_len = dss_pkg::TMR_W'(EXTREME_CYCLES);
      end else if (m == dss_pkg::DSS_TM_HIGH_OHM) begin
         samp_len = dss_pkg::TMR_W'(2 * SAMPLE_CYCLES);
      end else begin
         samp_len = dss_pkg::TMR_W'(SAMPLE_CYCLES);
      end
   endfunction
   // ------------------------------------------------------------------
   // Sequencer state machine
   // ------------------------------------------------------------------
   dss_pkg::dss_state_t st_q, st_d;
   logic [dss_pkg::TMR_W-1:0] tmr_q, tmr_d;
   logic [2:0] idx_q, idx_d;
   logic [15:0] cnt_q, cnt_d, res_q, res_d;
   logic cmp_prev_q, cmp_prev_d;
   logic sdone_d, rdone_d, beep_d;
   logic [1:0] div_d;
   logic half_hit, end_hit, group_short;
   // At or past the mark, so a mode change to a shorter sample cannot strand the timer
   assign end_hit = (tmr_q >= samp_len(tmode) - 1'b1);
   assign half_hit = (tmr_q >= (samp_len(tmode) >> 1) - 1'b1);
   // Autorange, overload, hold, knob and extremes modes deliver every sample alone
   assign group_short = (tmode == dss_pkg::DSS_TM_AUTORANGE) ||
                        (tmode == dss_pkg::DSS_TM_OVERLOAD) ||
                        (tmode == dss_pkg::DSS_TM_HOLD) ||
                        (tmode == dss_pkg::DSS_TM_KNOB) ||
                        (tmode == dss_pkg::DSS_TM_EXTREME);

   // Next state, timer, sample index and shared counter
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q + 1'b1;
      idx_d = idx_q;
      cnt_d = cnt_q;
      res_d = res_q;
      sdone_d = 1'b0;
      rdone_d = 1'b0;
      cmp_prev_d = cmp;
      unique case (st_q)
         dss_pkg::DSS_ST_IDLE: begin
            tmr_d = '0;
            if (tmode != dss_pkg::DSS_TM_COUNTER) begin
               st_d = dss_pkg::DSS_ST_AZERO; // start with a clean integrator
            end
         end
         dss_pkg::DSS_ST_INTEG: begin
            if (half_hit) begin
               st_d = dss_pkg::DSS_ST_READ;
            end
         end
         dss_pkg::DSS_ST_READ: begin
            if (cmp) begin
               cnt_d = cnt_q + 1'b1; // [R07]
            end
            if (end_hit) begin
               tmr_d = '0;
               sdone_d = 1'b1; // [R01] [R02]
               res_d = cnt_d; // [R05]
               if (idx_q == 3'(dss_pkg::SAMPLES_PER_GROUP - 1) || group_short) begin
                  idx_d = '0;
                  rdone_d = 1'b1; // [R03]
                  st_d = dss_pkg::DSS_ST_AZERO; // [R04] [R06]
               end else begin
                  idx_d = idx_q + 1'b1;
                  st_d = dss_pkg::DSS_ST_INTEG;
               end
            end
         end
         dss_pkg::DSS_ST_AZERO: begin
            if (tmr_q == dss_pkg::TMR_W'(AUTOZERO_CYCLES - 1)) begin
               tmr_d = '0;
               cnt_d = '0;
               res_d = '0;
               st_d = dss_pkg::DSS_ST_INTEG; // [R16]
            end
         end
      endcase
      if (tmode == dss_pkg::DSS_TM_COUNTER) begin
         st_d = dss_pkg::DSS_ST_IDLE;
         sdone_d = 1'b0;
         rdone_d = 1'b0;
         if (clr) begin
            cnt_d = '0; // [R14]
         end else if (arm && cmp && !cmp_prev_q) begin
            cnt_d = cnt_q + 1'b1; // [R08]
         end
      end
   end

   // Divider select and input alert
   always_comb begin
      unique case (range)
         dss_pkg::RANGE_40V: div_d = dss_pkg::DIV_100; // [R12]
         dss_pkg::RANGE_300V: div_d = dss_pkg::DIV_1000;
         default: div_d = dss_pkg::DIV_10;
      endcase
      beep_d = (!ma_n || !a_n) && // [R10]
               (func != dss_pkg::FUNC_MA) && (func != dss_pkg::FUNC_AMP); // [R11]
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= dss_pkg::DSS_ST_IDLE;
         tmr_q <= '0;
         idx_q <= '0;
         cnt_q <= '0;
         res_q <= '0;
         cmp_prev_q <= 1'b0;
         integrate_on <= 1'b0;
         deintegrate_on <= 1'b0;
         autozero_on <= 1'b0;
         sample_done <= 1'b0;
         reading_done <= 1'b0;
         count_out <= '0;
         residual_out <= '0;
         divider_sel <= dss_pkg::DIV_10;
         switch_drive <= '0;
         cmp_offset <= '0;
         beep_warn <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         res_q <= res_d;
         cmp_prev_q <= cmp_prev_d;
         integrate_on <= (st_d == dss_pkg::DSS_ST_INTEG);
         deintegrate_on <= (st_d == dss_pkg::DSS_ST_READ);
         autozero_on <= (st_d == dss_pkg::DSS_ST_AZERO);
         sample_done <= sdone_d;
         reading_done <= rdone_d;
         count_out <= cnt_d;
         residual_out <= res_d;
         divider_sel <= div_d;
         switch_drive <= sw_word; // [R13]
         cmp_offset <= offs; // [R09]
         beep_warn <= beep_d;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_az_len;
      @(posedge clk) disable iff (!rst_n)
      $rose(autozero_on) && tmode == dss_pkg::DSS_TM_BASIC |-> autozero_on [*8];
   endproperty
   a_az_len: assert property (p_az_len) else $error("autozero too short"); // [R04]
   property p_rd_after;
      @(posedge clk) disable iff (!rst_n)
      reading_done |-> sample_done && !integrate_on && autozero_on;
   endproperty
   a_rd_after: assert property (p_rd_after) else $error("reading not at group end"); // [R03]
   property p_sd_pulse;
      @(posedge clk) disable iff (!rst_n) sample_done |=> !sample_done;
   endproperty
   a_sd_pulse: assert property (p_sd_pulse) else $error("sample pulse too long"); // [R02]
   property p_beep;
      @(posedge clk) disable iff (!rst_n)
      (!ma_n && func == dss_pkg::FUNC_MA) ##1 (func == dss_pkg::FUNC_MA) |-> !beep_warn;
   endproperty
   a_beep: assert property (p_beep) else $error("beep in current function"); // [R11]
   property p_div;
      @(posedge clk) disable iff (!rst_n)
      range == dss_pkg::RANGE_40V |=> divider_sel == dss_pkg::DIV_100;
   endproperty
   a_div: assert property (p_div) else $error("wrong divider"); // [R12]
   property p_one_phase;
      @(posedge clk) disable iff (!rst_n)
      !(integrate_on && autozero_on) && !(integrate_on && deintegrate_on);
   endproperty
   a_one_phase: assert property (p_one_phase) else $error("phases overlap"); // [R07]
   property p_clr;
      @(posedge clk) disable iff (!rst_n)
      tmode == dss_pkg::DSS_TM_COUNTER && clr |=> count_out == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("counter not cleared"); // [R14]
   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      $fell(autozero_on) && tmode != dss_pkg::DSS_TM_COUNTER |-> integrate_on;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after autozero"); // [R16]
endmodule

// *** tb/dss_mcu_model.sv ***
// Microcomputer model that drives the sequencer's control inputs
`timescale 1ns/1ps
module dss_mcu_model (
   input wire logic clk,
   output logic [2:0] tmode,
   output logic [2:0] func,
   output logic [1:0] range,
   output logic [7:0] sw_word,
   output logic [3:0] offset,
   output logic arm,
   output logic clr
);
   // Power-up settings: basic timing, volts, low range
   initial begin
      tmode = 3'h0;
      func = 3'h0;
      range = 2'h0;
      sw_word = 8'h00;
      offset = 4'h0;
      arm = 1'b0;
      clr = 1'b0;
   end
   // Writes one function/range selection with its switch word
   task automatic select(input logic [2:0] f, input logic [1:0] r, input logic [7:0] w);
      @(negedge clk);
      func = f;
      range = r;
      sw_word = w;
   endtask
   // Picks the timing mode and the comparator offset
   task automatic set_mode(input logic [2:0] m, input logic [3:0] o);
      @(negedge clk);
      tmode = m;
      offset = o;
   endtask
   // Arms or clears the counter gate
   task automatic gate(input logic a, input logic c);
      @(negedge clk);
      arm = a;
      clr = c;
   endtask
endmodule

// *** tb/dss_sequencer_tb.sv ***
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module dss_sequencer_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmp = 1'b0;
   logic ma_n = 1'b1;
   logic a_n = 1'b1;
   logic [2:0] tm, fn;
   logic [1:0] rg, dsel;
   logic [7:0] sw, sdrv;
   logic [3:0] ofs, ofs_o;
   logic arm, clr, integ, deint, az, sdone, rdone, beep;
   logic [15:0] cnt, resid;
   int fail_count = 0;
   int check_count = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   dss_mcu_model mcu_u (.clk(clk), .tmode(tm), .func(fn), .range(rg), .sw_word(sw),
      .offset(ofs), .arm(arm), .clr(clr));
   dss_sequencer #(.SAMPLE_CYCLES(40), .AUTOZERO_CYCLES(64), .EXTREME_CYCLES(160)) dut_u (
      .clk(clk), .rst_n(rst_n), .tmode_async(tm), .func_async(fn), .range_async(rg),
      .switch_word_async(sw), .cmp_offset_async(ofs), .count_arm_async(arm),
      .count_clear_async(clr), .comparator_in(cmp), .milliamp_jack_sense(ma_n),
      .amp_jack_sense(a_n), .integrate_on(integ), .deintegrate_on(deint),
      .autozero_on(az), .sample_done(sdone), .reading_done(rdone), .count_out(cnt),
      .residual_out(resid), .divider_sel(dsel), .switch_drive(sdrv), .cmp_offset(ofs_o),
      .beep_warn(beep));
   // Compares one value and reports a mismatch
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Counts falling edges, and those with de-integrate on, up to the next sample end pulse
   task automatic wait_sample(output int n, output int d);
      n = 0;
      d = 0;
      do begin
         @(negedge clk);
         n++;
         if (deint === 1'b1) begin
            d++;
         end
      end while (sdone !== 1'b1 && n < 400);
   endtask
   // Basic group: autozero, eight samples, reading at the eighth; comparator held high
   task automatic t_basic();
      int n;
      int d;
      int i;
      cmp = 1'b1;
      i = 0;
      do begin
         wait_sample(n, d);
         i++;
      end while (rdone !== 1'b1 && i < 12);
      for (i = 0; i < 8; i++) begin
         wait_sample(n, d);
         chk("sample_gap", (i == 0) ? 16'h0068 : 16'h0028, 16'(n));
         chk("reading_done", (i == 7) ? 16'h0001 : 16'h0000, {15'h0, rdone});
         chk("deint_len", 16'h0014, 16'(d));
         chk("residual", 16'(20 * (i + 1)), resid);
         chk("count_out", 16'(20 * (i + 1)), cnt);
         chk("phase", (i == 7) ? 16'h0002 : 16'h0001, {14'h0, az, integ});
      end
      cmp = 1'b0;
   endtask
   // High-ohm doubles the sample; overload, autorange, hold and knob modes read every sample
   task automatic t_modes();
      logic [2:0] m [4] = '{3'h2, 3'h3, 3'h4, 3'h6};
      int n;
      int d;
      int i;
      mcu_u.set_mode(3'h1, 4'h0);
      i = 0;
      do begin
         wait_sample(n, d);
         i++;
      end while (rdone !== 1'b1 && i < 14);
      wait_sample(n, d);
      chk("hi_ohm_gap_az", 16'h0090, 16'(n));
      wait_sample(n, d);
      chk("hi_ohm_gap", 16'h0050, 16'(n));
      chk("hi_ohm_deint", 16'h0028, 16'(d));
      chk("hi_ohm_reading", 16'h0000, {15'h0, rdone});
      for (i = 0; i < 4; i++) begin
         mcu_u.set_mode(m[i], 4'h0);
         repeat (3) wait_sample(n, d);
         chk("short_gap", 16'h0068, 16'(n));
         chk("short_reading", 16'h0001, {15'h0, rdone});
      end
   endtask
   // Extremes mode: long sample, autozero and reading after each one
   task automatic t_extreme();
      int n;
      int d;
      mcu_u.set_mode(3'h5, 4'hA);
      repeat (3) wait_sample(n, d);
      wait_sample(n, d);
      chk("ext_gap", 16'h00E0, 16'(n));
      chk("ext_deint", 16'h0050, 16'(d));
      chk("ext_phase", 16'h0002, {14'h0, az, integ});
      chk("ext_reading", 16'h0001, {15'h0, rdone});
      chk("cmp_offset", 16'h000A, {12'h0, ofs_o});
   endtask
   // Range selects divider; switch word is passed on
   task automatic t_range();
      int r;
      for (r = 0; r < 3; r++) begin
         mcu_u.select(3'h0, 2'(r), 8'h5A + 8'(r));
         repeat (5) @(negedge clk);
         chk("divider_sel", 16'(r + 1), {14'h0, dsel});
         chk("switch_drive", 16'h005A + 16'(r), {8'h0, sdrv});
      end
   endtask
   // Jack alert against the selected function
   task automatic t_alert();
      logic [2:0] f [4] = '{3'h0, 3'h4, 3'h5, 3'h2};
      int i;
      for (i = 0; i < 8; i++) begin
         mcu_u.select(f[i % 4], 2'h0, 8'h00);
         ma_n = (i < 4) ? 1'b0 : 1'b1;
         a_n = (i < 4) ? 1'b1 : 1'b0;
         repeat (5) @(negedge clk);
         chk("beep_warn", {15'h0, (i % 4 == 0 || i % 4 == 3)}, {15'h0, beep});
      end
      ma_n = 1'b1;
      a_n = 1'b1;
      repeat (5) @(negedge clk);
      chk("beep_off", 16'h0000, {15'h0, beep});
   endtask
   // Counter mode counts comparator edges while armed
   task automatic t_count();
      mcu_u.set_mode(3'h7, 4'h3);
      repeat (4) @(negedge clk);
      mcu_u.gate(1'b1, 1'b1);
      mcu_u.gate(1'b1, 1'b0);
      repeat (5) @(negedge clk);
      repeat (5) begin
         cmp = 1'b1;
         repeat (3) @(negedge clk);
         cmp = 1'b0;
         repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      chk("count_armed", 16'h0005, cnt);
      mcu_u.gate(1'b0, 1'b0);
      repeat (4) @(negedge clk);
      cmp = 1'b1;
      repeat (6) @(negedge clk);
      chk("count_disarmed", 16'h0005, cnt);
      mcu_u.gate(1'b0, 1'b1);
      repeat (5) @(negedge clk);
      chk("count_clear", 16'h0000, cnt);
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      chk("reset_div", 16'h0001, {14'h0, dsel});
      chk("reset_count", 16'h0000, cnt);
      rst_n = 1'b1;
      t_basic();
      t_range();
      t_alert();
      t_modes();
      t_extreme();
      t_count();
      give_verdict();
   end
   // Watchdog against a hang
   initial begin
      #(20 * 20000);
      fail_count++;
      give_verdict();
   end
endmodule
